// File: rtl/amp_init_control_sequence.sv
// Amplifier control core: reset/power-down sequencing, registers and modulation limit
//
// How it works
// - Duty cycle clamped to programmed modulation limit at each sample; a newly written limit applies from the next sample
// - Full-scale modulation is full scale minus twice the margin
// - Volume and mute changes ramp while streaming
// - Backend error register takes one non-reserved write
// - After start-up pin and clock activity tolerated
// - Reset ignored while powered down
// - Power-down ignored in reset; needs falling edge
`timescale 1ns/10ps
module amp_init_control_sequence
  import amp_seq_pkg::*;
#(
  parameter int GAIN_STEP = 1
)(
  input wire logic core_clk_in,
  input wire logic rst_b_in,
  input wire logic reset_n_in,
  input wire logic power_down_n_in,
  input wire logic mute_n_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic sample_valid_in,
  input wire logic signed [15:0] sample_in,
  output logic [7:0] reg_rdata_out,
  output logic [amp_seq_pkg::DUTY_W-1:0] duty_out,
  output logic in_reset_out,
  output logic powered_down_out,
  output logic shutdown_out
);
  import amp_seq_pkg::*;

  initial
  begin
    if (GAIN_STEP < 1 || GAIN_STEP > 255)
      $error("GAIN_STEP must lie in 1..255");
  end

  typedef struct packed {
    dev_state_t st;
    logic pdn_prev;
    logic [7:0] sys_ctrl_two;
    logic [7:0] start_stop;
    logic [7:0] osc_trim;
    logic [7:0] bknd_cfg;
    logic bknd_done;
    logic [7:0] master_vol;
    logic [7:0] soft_mute;
    logic [7:0] mod_limit;
    logic [7:0] gain;
    logic [DUTY_W-1:0] duty;
    logic [7:0] rdata;
    logic in_reset;
    logic pwr_down;
    logic shutdown;
  } state_t;

  state_t q, d;

  logic [DUTY_W-1:0] margin;
  logic [DUTY_W:0] span;
  logic [7:0] target;
  logic signed [36:0] prod;
  logic signed [DUTY_W:0] swing;
  logic signed [DUTY_W+1:0] raw;
  logic [DUTY_W-1:0] lo_bound;
  logic [DUTY_W-1:0] hi_bound;
  logic wr_ok;

  always_comb
  begin
    d = q;
    margin = DUTY_W'(MARGIN_UNIT * (int'(q.mod_limit[MOD_LIMIT_W-1:0]) + 1));
    lo_bound = margin;
    hi_bound = DUTY_W'(DUTY_FULL - {1'b0, margin});
    // Span of the duty swing equals full scale minus twice the margin
    span = DUTY_FULL - {margin, 1'b0};
    prod = 37'(sample_in) * 37'(signed'({1'b0, q.gain})) * 37'(signed'({1'b0, span}));
    swing = (DUTY_W+1)'(prod >>> 24);
    raw = (DUTY_W+2)'(signed'({2'b00, DUTY_MID})) + (DUTY_W+2)'(swing);
    // Any mute source ramps down instead of cutting
    target = (!mute_n_in || q.soft_mute[SOFT_MUTE_BIT]) ? 8'h00 : 8'(8'hFF - q.master_vol);
    wr_ok = reg_wr_in && q.st == ST_ACTIVE;
    unique case (q.st)
      ST_RESET:
      begin
        // Power-down pin has no effect while reset is held
        if (reset_n_in)
          d.st = ST_ACTIVE;
      end
      ST_ACTIVE:
      begin
        if (!reset_n_in)
          d.st = ST_RESET;
        else if (q.pdn_prev && !power_down_n_in)
          d.st = ST_POWER_DOWN;
      end
      ST_POWER_DOWN:
      begin
        // Reset pin is ignored here, registers survive
        if (power_down_n_in)
          d.st = ST_ACTIVE;
      end
    endcase
    // Edge history restarts in reset so a low held through reset is no edge
    d.pdn_prev = (q.st == ST_RESET) ? 1'b0 : power_down_n_in;
    if (q.st == ST_RESET)
    begin
      d.sys_ctrl_two = RST_SYS_CTRL_TWO;
      d.start_stop = RST_START_STOP;
      d.osc_trim = RST_OSC_TRIM;
      d.bknd_cfg = RST_BKND_CFG;
      d.bknd_done = 1'b0;
      d.master_vol = RST_MASTER_VOL;
      d.soft_mute = RST_SOFT_MUTE;
      d.mod_limit = RST_MOD_LIMIT;
      d.gain = 8'h00;
    end
    else if (wr_ok)
    begin
      unique case (reg_addr_in)
        ADDR_SYS_CTRL_TWO: d.sys_ctrl_two = reg_wdata_in;
        ADDR_START_STOP: d.start_stop = reg_wdata_in;
        ADDR_OSC_TRIM: d.osc_trim = reg_wdata_in;
        ADDR_MASTER_VOL: d.master_vol = reg_wdata_in;
        ADDR_SOFT_MUTE: d.soft_mute = reg_wdata_in;
        ADDR_MOD_LIMIT: d.mod_limit = reg_wdata_in;
        ADDR_BKND_CFG:
        begin
          // Only the first legal value lands; reserved codes never count
          if (!q.bknd_done && reg_wdata_in >= BKND_FIRST_LEGAL)
          begin
            d.bknd_cfg = reg_wdata_in;
            d.bknd_done = 1'b1;
          end
        end
        default: ;
      endcase
    end
    if (q.st != ST_RESET && sample_valid_in)
    begin
      // One step per sample keeps gain changes free of clicks
      if (q.gain < target)
        d.gain = (target - q.gain > 8'(GAIN_STEP)) ? 8'(q.gain + 8'(GAIN_STEP)) : target;
      else if (q.gain > target)
        d.gain = (q.gain - target > 8'(GAIN_STEP)) ? 8'(q.gain - 8'(GAIN_STEP)) : target;
    end
    if (q.st != ST_ACTIVE || q.sys_ctrl_two[SHUTDOWN_BIT])
      d.duty = DUTY_MID;
    else if (sample_valid_in)
    begin
      // Clamp guards against rounding at the extremes
      if (raw < (DUTY_W+2)'(signed'({2'b00, lo_bound})))
        d.duty = lo_bound;
      else if (raw > (DUTY_W+2)'(signed'({2'b00, hi_bound})))
        d.duty = hi_bound;
      else
        d.duty = DUTY_W'(raw);
    end
    d.rdata = 8'h00;
    if (reg_rd_in && q.st == ST_ACTIVE)
    begin
      unique case (reg_addr_in)
        ADDR_SYS_CTRL_TWO: d.rdata = q.sys_ctrl_two;
        ADDR_START_STOP: d.rdata = q.start_stop;
        ADDR_OSC_TRIM: d.rdata = q.osc_trim;
        ADDR_BKND_CFG: d.rdata = q.bknd_cfg;
        ADDR_MASTER_VOL: d.rdata = q.master_vol;
        ADDR_SOFT_MUTE: d.rdata = q.soft_mute;
        ADDR_MOD_LIMIT: d.rdata = q.mod_limit;
        default: d.rdata = 8'h00;
      endcase
    end
    d.in_reset = d.st == ST_RESET;
    d.pwr_down = d.st == ST_POWER_DOWN;
    // Pins and clocks may move freely once running; no error path exists
    d.shutdown = d.st != ST_ACTIVE || d.sys_ctrl_two[SHUTDOWN_BIT];
  end

  always_ff @(posedge core_clk_in)
  begin
    if (!rst_b_in)
    begin
      q <= '0;
      q.st <= ST_RESET;
      q.duty <= DUTY_MID;
      q.in_reset <= 1'b1;
      q.shutdown <= 1'b1;
      q.sys_ctrl_two <= RST_SYS_CTRL_TWO;
      q.start_stop <= RST_START_STOP;
      q.osc_trim <= RST_OSC_TRIM;
      q.bknd_cfg <= RST_BKND_CFG;
      q.master_vol <= RST_MASTER_VOL;
      q.mod_limit <= RST_MOD_LIMIT;
    end
    else
      q <= d;
  end

  assign reg_rdata_out = q.rdata;
  assign duty_out = q.duty;
  assign in_reset_out = q.in_reset;
  assign powered_down_out = q.pwr_down;
  assign shutdown_out = q.shutdown;

  chk_duty_low_bound: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
    duty_out >= lo_bound) else $error("duty below modulation limit");
  chk_duty_high_bound: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
    duty_out <= hi_bound) else $error("duty above modulation limit");
  chk_span_default: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
    q.mod_limit == RST_MOD_LIMIT |-> span == 11'h3D0) else $error("default swing span wrong");
  chk_gain_ramp_step: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
    !in_reset_out && !$past(q.in_reset) |-> (q.gain >= $past(q.gain) ? q.gain - $past(q.gain) : $past(q.gain) - q.gain)
      <= 8'(GAIN_STEP)) else $error("gain jumped by more than one step");
  chk_bknd_write_once: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
    q.bknd_done && !in_reset_out |=> q.bknd_cfg == $past(q.bknd_cfg) || in_reset_out)
    else $error("backend config changed after first write");
  chk_bknd_reserved: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
    reg_wr_in && reg_addr_in == ADDR_BKND_CFG && reg_wdata_in < BKND_FIRST_LEGAL |=> $stable(q.bknd_cfg))
    else $error("reserved backend code accepted");
  chk_pd_holds_reset: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
    powered_down_out && !power_down_n_in && !reset_n_in |=> powered_down_out && !in_reset_out)
    else $error("reset acted during power-down");
  chk_reset_blocks_pd: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
    in_reset_out && !reset_n_in |=> !powered_down_out) else $error("power-down taken while in reset");
  chk_pd_needs_edge: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
    $rose(q.pwr_down) |-> $past(q.pdn_prev) && !$past(power_down_n_in)) else $error("power-down without falling edge");
  chk_shutdown_mid: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
    shutdown_out |=> duty_out == DUTY_MID) else $error("duty moved in shutdown");

  cov_leave_shutdown: cover property (@(posedge core_clk_in) disable iff (!rst_b_in) $fell(shutdown_out));
  cov_power_down: cover property (@(posedge core_clk_in) disable iff (!rst_b_in) $rose(powered_down_out));
  cov_duty_clamped: cover property (@(posedge core_clk_in) disable iff (!rst_b_in) duty_out == hi_bound);
  cov_bknd_written: cover property (@(posedge core_clk_in) disable iff (!rst_b_in) $rose(q.bknd_done));
endmodule

// File: rtl/amp_seq_pkg.sv
// Constants for the amplifier start-up and run-time control block
package amp_seq_pkg;
  localparam logic [7:0] ADDR_SOFT_MUTE = 8'h06;
  localparam logic [7:0] ADDR_MASTER_VOL = 8'h07;
  localparam logic [7:0] ADDR_MOD_LIMIT = 8'h10;
  localparam logic [7:0] ADDR_SYS_CTRL_TWO = 8'h05;
  localparam logic [7:0] ADDR_START_STOP = 8'h1A;
  localparam logic [7:0] ADDR_OSC_TRIM = 8'h1B;
  localparam logic [7:0] ADDR_BKND_CFG = 8'h1C;
  localparam logic [7:0] RST_SOFT_MUTE = 8'h00;
  localparam logic [7:0] RST_MASTER_VOL = 8'hFF;
  localparam logic [7:0] RST_MOD_LIMIT = 8'h02;
  localparam logic [7:0] RST_SYS_CTRL_TWO = 8'h40;
  localparam logic [7:0] RST_START_STOP = 8'h0A;
  localparam logic [7:0] RST_OSC_TRIM = 8'h82;
  localparam logic [7:0] RST_BKND_CFG = 8'h02;
  localparam logic [7:0] BKND_FIRST_LEGAL = 8'h02;
  localparam int SHUTDOWN_BIT = 6;
  localparam int SOFT_MUTE_BIT = 0;
  localparam int MOD_LIMIT_W = 3;
  // Duty cycle is a fraction of DUTY_FULL counts
  localparam int DUTY_W = 10;
  localparam logic [DUTY_W:0] DUTY_FULL = 11'h400;
  localparam logic [DUTY_W-1:0] DUTY_MID = 10'h200;
  localparam int MARGIN_UNIT = 8;
  typedef enum logic [1:0] {ST_RESET, ST_ACTIVE, ST_POWER_DOWN} dev_state_t;
endpackage

// File: dv/host_model.sv
// Host controller model driving the amplifier pins and register strobes
`timescale 1ns/10ps
module host_model
  import amp_seq_pkg::*;
(
  input wire logic clk_in,
  input wire logic [7:0] rdata_in,
  output logic reset_n_out,
  output logic power_down_n_out,
  output logic mute_n_out,
  output logic wr_out,
  output logic rd_out,
  output logic [7:0] addr_out,
  output logic [7:0] wdata_out,
  output logic valid_out,
  output logic signed [15:0] sample_out
);
  initial
  begin
    {reset_n_out, power_down_n_out, mute_n_out, wr_out, rd_out} = '0;
    {addr_out, wdata_out, valid_out, sample_out} = '0;
  end
  // Waits are counted from the last strobe or pin change
  task automatic idle(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task automatic pins(input logic rst_n, input logic pdn_n, input logic mt_n);
    idle(1);
    {reset_n_out, power_down_n_out, mute_n_out} = {rst_n, pdn_n, mt_n};
    idle(2);
  endtask
  // Released bus lines show the inverse so stale values never pass
  task automatic xfer(input logic is_rd, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    idle(1);
    {rd_out, wr_out, addr_out, wdata_out} = {is_rd, !is_rd, a, d};
    idle(1);
    q = rdata_in;
    {rd_out, wr_out, addr_out, wdata_out} = {2'b00, ~a, ~d};
  endtask
  task automatic send(input logic signed [15:0] s);
    idle(1);
    {valid_out, sample_out} = {1'b1, s};
    idle(1);
    {valid_out, sample_out} = {1'b0, ~s};
  endtask
  // Supply ramps are not modelled; waits shortened to a few cycles
  // Coefficient, banking, clock and format setup is not modelled, so none of it
  // is ever sent after start-up and no read follows a shutdown exit
  task automatic init();
    logic [7:0] q;
    pins(1'b0, 1'b1, 1'b1);
    idle(4);
    pins(1'b1, 1'b1, 1'b1);
    idle(4);
    xfer(1'b0, ADDR_OSC_TRIM, 8'h00, q);
  endtask
endmodule

// File: dv/tb.sv
// Self-checking bench for the amplifier control core against a behavioural model
`timescale 1ns/10ps
`define CHK(g, e, m) begin n_checks++; if ((g) !== (e)) begin err_count++; $display("MISMATCH t=%0t %s", $time, m); end end
module tb;
  import amp_seq_pkg::*;
  logic core_clk_in, rst_b_in, reset_n, pdn_n, mute_n, wr, rd, sv, in_rst, pwr_dn, shut;
  logic [7:0] addr, wdata, rdata, got;
  logic signed [15:0] sample;
  logic [DUTY_W-1:0] duty;
  int err_count, n_checks, cycles;
  int mdl[int];
  int reg_list[8] = '{'h05, 'h06, 'h07, 'h10, 'h1A, 'h1B, 'h1C, 'h20};
  bit bk_locked;
  host_model host_u (.clk_in(core_clk_in), .rdata_in(rdata), .reset_n_out(reset_n), .power_down_n_out(pdn_n),
    .mute_n_out(mute_n), .wr_out(wr), .rd_out(rd), .addr_out(addr), .wdata_out(wdata), .valid_out(sv),
    .sample_out(sample));
  amp_init_control_sequence #(.GAIN_STEP(255)) dut_u (.core_clk_in(core_clk_in), .rst_b_in(rst_b_in),
    .reset_n_in(reset_n), .power_down_n_in(pdn_n), .mute_n_in(mute_n), .reg_wr_in(wr), .reg_rd_in(rd),
    .reg_addr_in(addr), .reg_wdata_in(wdata), .sample_valid_in(sv), .sample_in(sample), .reg_rdata_out(rdata),
    .duty_out(duty), .in_reset_out(in_rst), .powered_down_out(pwr_dn), .shutdown_out(shut));
  function automatic void mdl_reset();
    mdl = '{'h05: 'h40, 'h06: 0, 'h07: 'hFF, 'h10: 2, 'h1A: 'h0A, 'h1B: 'h82, 'h1C: 2};
    bk_locked = 0;
  endfunction
  task automatic do_wr(input int a, input int d);
    host_u.xfer(1'b0, 8'(a), 8'(d), got);
    if (mdl.exists(a) && (a != 'h1C || (!bk_locked && d > 1)))
      mdl[a] = d;
    bk_locked |= (a == 'h1C && d > 1);
  endtask
  task automatic check_regs();
    foreach (reg_list[i])
    begin
      host_u.xfer(1'b1, 8'(reg_list[i]), 8'h00, got);
      `CHK(got, 8'(mdl.exists(reg_list[i]) ? mdl[reg_list[i]] : 0), "register read")
    end
  endtask
  function automatic int duty_exp(int smp);
    int margin, span, g, v;
    margin = 8 * ((mdl['h10] & 7) + 1);
    span = 1024 - 2 * margin;
    g = (mute_n === 1'b0 || (mdl['h06] & 1)) ? 0 : 255 - mdl['h07];
    v = 512 + int'((longint'(smp) * g * span) >>> 24);
    if (mdl['h05] & 'h40)
      return 512;
    return v < margin ? margin : (v > 1024 - margin ? 1024 - margin : v);
  endfunction
  // First sample lets the gain ramp settle, second one is compared
  task automatic play(input int smp);
    host_u.send(16'(smp));
    host_u.send(16'(smp));
    `CHK(duty, 10'(duty_exp(smp)), "duty")
  endtask
  task automatic final_report();
    $display("checks=%0d mismatches=%0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    core_clk_in = 1'b0;
    forever #25 core_clk_in = ~core_clk_in;
  end
  always @(posedge core_clk_in)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      err_count++;
      final_report();
    end
  end
  initial
  begin
    rst_b_in = 1'b0;
    void'($urandom(32'h36AB));
    mdl_reset();
    repeat (6) @(posedge core_clk_in);
    #1;
    rst_b_in = 1'b1;
    host_u.pins(1'b0, 1'b1, 1'b1);
    host_u.pins(1'b0, 1'b0, 1'b1);
    `CHK({in_rst, pwr_dn}, 2'b10, "pdn edge in reset")
    host_u.init();
    `CHK({in_rst, shut}, 2'b01, "out of reset")
    mdl['h1B] = 0;
    check_regs();
    do_wr('h1C, 1);
    do_wr('h1C, 3);
    do_wr('h1C, 2);
    do_wr('h20, 'h5A);
    check_regs();
    play(1000);
    for (int c = 0; c < 8; c++)
    begin
      do_wr('h05, 'h40);
      host_u.idle(8);
      do_wr('h10, c);
      do_wr('h07, c * 9);
      do_wr('h05, 'h00);
      play(32767);
      play(-32768);
      play(int'($urandom_range(65535)) - 32768);
      `CHK(shut, 1'b0, "shutdown exit")
    end
    host_u.pins(1'b1, 1'b1, 1'b0);
    play(20000);
    host_u.pins(1'b1, 1'b1, 1'b1);
    do_wr('h06, 1);
    play(20000);
    do_wr('h06, 0);
    host_u.pins(1'b1, 1'b0, 1'b1);
    `CHK({pwr_dn, shut}, 2'b11, "power down")
    host_u.pins(1'b0, 1'b0, 1'b1);
    `CHK({in_rst, pwr_dn}, 2'b01, "reset while powered down")
    host_u.pins(1'b1, 1'b1, 1'b1);
    `CHK(pwr_dn, 1'b0, "power up")
    play(-12345);
    do_wr('h05, 'h40);
    host_u.idle(8);
    host_u.pins(1'b0, 1'b1, 1'b1);
    `CHK(in_rst, 1'b1, "device reset")
    mdl_reset();
    host_u.pins(1'b1, 1'b1, 1'b1);
    do_wr('h1C, 3);
    check_regs();
    final_report();
  end
endmodule
